// ---- dv/osc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module osc_model #(
  parameter int HALF_NS = 410,
  parameter int PHASE_NS = 3
) (
  // Oscillator output
  output logic osc
);
  initial begin
    osc = 1'b0;
    // Offset keeps oscillator edges off the clock edges
    #(PHASE_NS);
    forever #(HALF_NS) osc = ~osc;
  end
endmodule : osc_model
`default_nettype wire

// ---- dv/tb_independent_timeout_watchdog.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_independent_timeout_watchdog;
  import watchdog_pkg::*;
  logic clock, rst_b, lowSpeedOsc, hwOpt, halted, freeze, standbyExit;
  logic regWrite, regRead, watchdogReset, unl;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWriteData, regReadData, q, mRel, mDiv;
  int mismatches, check_count, seed, i, rl, dv;
  independent_timeout_watchdog u_independent_timeout_watchdog (.clock, .rst_b, .lowSpeedOsc,
    .hardwareWatchdogOption(hwOpt), .debugHalted(halted), .debugHaltFreeze(freeze), .standbyExit,
    .regAddr, .regWrite, .regRead, .regWriteData, .regReadData, .watchdogReset);
  osc_model u_osc_model (.osc(lowSpeedOsc));
  initial clock = 1'b0;
  always #50 clock = ~clock;
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    regWrite = w;
    regRead = !w;
    regAddr = a;
    regWriteData = d;
    @(posedge clock);
    #1;
    q = regReadData;
    if (w && a == ADDR_COMMAND) unl = d[15:0] == KEY_UNLOCK;
    if (w && unl && a == ADDR_RELOAD) mRel = d[11:0];
    if (w && unl && a == ADDR_DIVIDER) mDiv = d[2:0];
  endtask : bus
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
    chk(q, a == ADDR_RELOAD ? mRel : a == ADDR_DIVIDER ? mDiv : 32'h0);
  endtask : rd
  task automatic idle();
    regWrite = 1'b0;
    regRead = 1'b0;
    @(posedge clock);
    #1;
  endtask : idle
  task automatic settle();
    int n;
    bus(1'b0, ADDR_FLAGS, 32'h0);
    for (n = 0; n < 50 && q[1:0] !== 2'b00; n++) bus(1'b0, ADDR_FLAGS, 32'h0);
    chk(q, 32'h0);
  endtask : settle
  task automatic doReset();
    rst_b = 1'b0;
    unl = 1'b0;
    mRel = 32'hfff;
    mDiv = 32'h0;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    chk(watchdogReset, 1'b0);
  endtask : doReset
  task automatic fire(input int r, input int d);
    int k;
    time t0;
    t0 = $time;
    for (k = 0; k < 12000 && watchdogReset !== 1'b1; k++) idle();
    chk(watchdogReset, 1'b1);
    chk($time - t0 + 820 >= r * d * 820, 1'b1);
    chk($time - t0 <= ((r + 1) * d + 2) * 820, 1'b1);
  endtask : fire
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // ----
  // Sequence
  // ----
  initial begin
    seed = 96881;
    mismatches = 0;
    check_count = 0;
    {hwOpt, halted, freeze, standbyExit, regWrite, regRead} = 6'h0;
    regAddr = 4'h0;
    regWriteData = 32'h0;
    doReset();
    for (i = 0; i < 16; i++) rd(i[3:0]);
    rl = 2 + ($random(seed) & 1);
    bus(1'b1, ADDR_RELOAD, 32'(rl));
    bus(1'b1, ADDR_COMMAND, KEY_UNLOCK);
    bus(1'b1, ADDR_COMMAND, KEY_REFRESH);
    bus(1'b1, ADDR_RELOAD, 32'(rl));
    rd(ADDR_RELOAD);
    bus(1'b1, ADDR_COMMAND, KEY_UNLOCK);
    bus(1'b1, ADDR_DIVIDER, 32'h7);
    bus(1'b1, ADDR_RELOAD, 32'(rl));
    bus(1'b0, ADDR_FLAGS, 32'h0);
    chk(q, 32'h3);
    settle();
    for (i = 0; i < 16; i++) rd(i[3:0]);
    standbyExit = 1'b1;
    idle();
    standbyExit = 1'b0;
    unl = 1'b0;
    mRel = 32'hfff;
    for (i = 0; i < 16; i++) rd(i[3:0]);
    bus(1'b1, ADDR_RELOAD, 32'(rl));
    rd(ADDR_RELOAD);
    for (i = 0; i < 8; i++) begin
      hwOpt = i == 7;
      halted = i[0];
      doReset();
      rl = 2 + ($random(seed) & 1);
      bus(1'b1, ADDR_COMMAND, KEY_UNLOCK);
      bus(1'b1, ADDR_RELOAD, 32'(rl));
      bus(1'b1, ADDR_DIVIDER, 32'(i));
      settle();
      if (i != 7) bus(1'b1, ADDR_COMMAND, KEY_START);
      bus(1'b1, ADDR_COMMAND, KEY_REFRESH);
      dv = 4 << (i > 6 ? 6 : i);
      fire(rl, dv);
    end
    {hwOpt, halted} = 2'b00;
    doReset();
    bus(1'b1, ADDR_COMMAND, KEY_UNLOCK);
    bus(1'b1, ADDR_RELOAD, 32'h2);
    settle();
    bus(1'b1, ADDR_COMMAND, KEY_START);
    bus(1'b1, ADDR_COMMAND, KEY_REFRESH);
    repeat (12) idle();
    {halted, freeze} = 2'b11;
    repeat (300) idle();
    chk(watchdogReset, 1'b0);
    halted = 1'b0;
    fire(0, 12);
    results();
  end
  initial begin
    #8_000_000;
    mismatches++;
    results();
  end
endmodule : tb_independent_timeout_watchdog
`default_nettype wire

// ---- dv/watchdog_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module watchdog_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Design inputs
  input wire logic lowSpeedOsc,
  input wire logic hardwareWatchdogOption,
  input wire logic debugHalted,
  input wire logic debugHaltFreeze,
  input wire logic standbyExit,
  input wire logic [watchdog_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [watchdog_pkg::DATA_W-1:0] regWriteData,
  // Design outputs
  input wire logic [watchdog_pkg::DATA_W-1:0] regReadData,
  input wire logic watchdogReset
);
  import watchdog_pkg::*;
  // ----
  // Helper state
  // ----
  logic unlocked;
  logic started;
  logic [2:0] relEdges;
  logic [2:0] divEdges;
  wire logic [15:0] key = regWriteData[15:0];
  wire logic cmdWr = regWrite && regAddr == ADDR_COMMAND;
  wire logic relWr = regWrite && regAddr == ADDR_RELOAD && unlocked;
  wire logic divWr = regWrite && regAddr == ADDR_DIVIDER && unlocked;
  wire logic flagRd = regRead && regAddr == ADDR_FLAGS;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      unlocked <= 1'b0;
      started <= 1'b0;
      relEdges <= 3'h0;
      divEdges <= 3'h0;
    end else begin
      if (cmdWr && key == KEY_UNLOCK) unlocked <= 1'b1;
      else if (cmdWr || standbyExit) unlocked <= 1'b0;
      started <= started || hardwareWatchdogOption || (cmdWr && key == KEY_START);
      relEdges <= relWr ? 3'h0 : relEdges + 3'($rose(lowSpeedOsc) && relEdges != 3'h7);
      divEdges <= divWr ? 3'h0 : divEdges + 3'($rose(lowSpeedOsc) && divEdges != 3'h7);
    end
  end
  // ----
  // Properties
  // ----
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_relSet; relWr ##1 flagRd; endsequence
  sequence s_divSet; divWr ##1 flagRd; endsequence
  AST_HOLD: assert property (watchdogReset |=> watchdogReset)
    else $error("reset request dropped");
  AST_IDLE: assert property (!started |-> !watchdogReset)
    else $error("reset while idle");
  AST_CMD_ZERO: assert property (regRead && regAddr == ADDR_COMMAND |=> regReadData == READ_ZERO)
    else $error("command read not zero");
  AST_RL_TOP: assert property (regRead && regAddr == ADDR_RELOAD |=> regReadData[31:12] == 20'h0)
    else $error("reload upper bits set");
  AST_RL_SET: assert property (s_relSet |=> regReadData[FLAG_RELOAD_BIT])
    else $error("reload pending not set");
  AST_DV_SET: assert property (s_divSet |=> regReadData[FLAG_DIVIDER_BIT])
    else $error("divider pending not set");
  AST_RL_CLR: assert property (flagRd && relEdges > 3'h5 |=> !regReadData[FLAG_RELOAD_BIT])
    else $error("reload pending stuck");
  AST_DV_CLR: assert property (flagRd && divEdges > 3'h5 |=> !regReadData[FLAG_DIVIDER_BIT])
    else $error("divider pending stuck");
  AST_FREEZE: assert property ((debugHalted && debugHaltFreeze) [*8] |=> !$rose(watchdogReset))
    else $error("expiry while frozen");
endmodule : watchdog_monitor
bind independent_timeout_watchdog watchdog_monitor u_watchdog_monitor (.clock, .rst_b, .lowSpeedOsc,
  .hardwareWatchdogOption, .debugHalted, .debugHaltFreeze, .standbyExit, .regAddr, .regWrite,
  .regRead, .regWriteData, .regReadData, .watchdogReset);
`default_nettype wire

// ---- hw/independent_timeout_watchdog.sv ----
// Behaviour
// - start command word begins countdown from all ones
// - divided tick with counter already at zero asserts the watchdog system reset
// - refresh command word reloads counter from programmed reload value
// - hardware option starts counting at power-on without a command
// - divider and reload writes accepted only after unlock word
// - any other command word re-locks divider and reload
// - debug halt freezes or keeps counting per freeze bit
// - codes 0..6 divide by 4..256, code 7 divides by 256
// - command register is write-only and reads zero
// - timeout is divider times reload plus one oscillator periods
// - reload value returns to all ones on reset and standby exit
// - status clears on reset, kept across standby
// - reload pending flag set during crossing, clears within five oscillator cycles
// - divider pending flag set during crossing, clears within five oscillator cycles
// - divider reads return the oscillator-side copy
// - a started update completes regardless of low-power entry
// - counter steps on low-speed oscillator edges sampled on the main clock
// - timeout may differ by up to one divided tick from prescaler phase, as refresh does not clear the prescaler
`timescale 1ns/10ps
`default_nettype none
module independent_timeout_watchdog #(
  parameter int PRESCALE_W = watchdog_pkg::PRESCALE_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Low-speed oscillator, sampled
  input wire logic lowSpeedOsc,
  // Option, debug and power state
  input wire logic hardwareWatchdogOption,
  input wire logic debugHalted,
  input wire logic debugHaltFreeze,
  input wire logic standbyExit,
  // Register port
  input wire logic [watchdog_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [watchdog_pkg::DATA_W-1:0] regWriteData,
  output logic [watchdog_pkg::DATA_W-1:0] regReadData,
  // System reset request
  output logic watchdogReset
);
  import watchdog_pkg::*;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    RUNNING = 3'b010,
    EXPIRED = 3'b100
  } wdt_state_e;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  wdt_state_e state;
  wdt_state_e next_state;
  logic oscPrev;
  logic oscEdge;
  logic unlocked;
  logic startPending;
  logic refreshPending;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [DIV_W-1:0] dividerCopy;
  logic [COUNT_W-1:0] reloadCopy;
  logic dividerPending;
  logic reloadPending;
  logic tick;
  logic frozen;
  logic counting;
  logic applyCommand;

  // Decode of the register port
  wire selCommand = (regAddr == ADDR_COMMAND);
  wire selDivider = (regAddr == ADDR_DIVIDER);
  wire selReload = (regAddr == ADDR_RELOAD);
  wire selFlags = (regAddr == ADDR_FLAGS);
  wire [KEY_W-1:0] key = regWriteData[KEY_W-1:0];
  wire cmdWrite = regWrite && selCommand;
  wire startWrite = cmdWrite && (key == KEY_START);
  wire refreshWrite = cmdWrite && (key == KEY_REFRESH);
  wire unlockWrite = cmdWrite && (key == KEY_UNLOCK);
  wire dividerWrite = regWrite && selDivider && unlocked;
  wire reloadWrite = regWrite && selReload && unlocked;

  // ----------------------------------------
  // Oscillator edge
  // ----------------------------------------
  // oscillator sampling
  assign oscEdge = lowSpeedOsc && !oscPrev;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oscPrev <= 1'b0;
    end else begin
      oscPrev <= lowSpeedOsc;
    end
  end

  // ----------------------------------------
  // Write protection
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      unlocked <= 1'b0;
    end else if (unlockWrite) begin
      unlocked <= 1'b1;
    end else if (cmdWrite || standbyExit) begin
      unlocked <= 1'b0;
    end
  end

  // ----------------------------------------
  // Divider and reload crossing
  // ----------------------------------------
  // divider pending flag
  update_tracker #(
    .WIDTH(DIV_W),
    .RESET_VALUE(DIVIDER_RESET)
  ) dividerTracker (
    .clock(clock),
    .rst_b(rst_b),
    .oscEdge(oscEdge),
    .loadDefault(1'b0),
    .request(dividerWrite),
    .requestData(regWriteData[DIV_W-1:0]),
    .pending(dividerPending),
    .oscCopy(dividerCopy)
  );

  update_tracker #(
    .WIDTH(COUNT_W),
    .RESET_VALUE(RELOAD_RESET)
  ) reloadTracker (
    .clock(clock),
    .rst_b(rst_b),
    .oscEdge(oscEdge),
    .loadDefault(standbyExit),
    .request(reloadWrite),
    .requestData(regWriteData[COUNT_W-1:0]),
    .pending(reloadPending),
    .oscCopy(reloadCopy)
  );

  // ----------------------------------------
  // Command handshake
  // ----------------------------------------
  // command applied once
  assign applyCommand = oscEdge;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      startPending <= 1'b0;
      refreshPending <= 1'b0;
    end else begin
      startPending <= startWrite || (startPending && !applyCommand);
      refreshPending <= refreshWrite || (refreshPending && !applyCommand);
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // debug freeze
  assign frozen = debugHalted && debugHaltFreeze;
  assign counting = (state == RUNNING) && !frozen;

  osc_prescaler #(
    .PRESCALE_W(PRESCALE_W)
  ) prescaler (
    .clock(clock),
    .rst_b(rst_b),
    .oscEdge(oscEdge),
    .run(counting),
    .divSel(dividerCopy),
    .tick(tick)
  );

  // ----------------------------------------
  // State and counter
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (startPending && applyCommand) begin
          next_state = RUNNING;
        end
      end
      RUNNING: begin
        if (tick && (count == COUNT_ZERO) && !(refreshPending && applyCommand)) begin
          next_state = EXPIRED;
        end
      end
      EXPIRED: begin
        next_state = EXPIRED;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_comb begin
    next_count = count;
    if (refreshPending && applyCommand) begin
      next_count = reloadCopy;
    end else if (tick && (count != COUNT_ZERO)) begin
      next_count = count - 12'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= IDLE;
    end else if (hardwareWatchdogOption && (state == IDLE)) begin
      state <= RUNNING;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= COUNT_START;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      watchdogReset <= 1'b0;
    end else begin
      watchdogReset <= (next_state == EXPIRED);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [DATA_W-1:0] flagsWord = DATA_W'({reloadPending, dividerPending});
  wire [DATA_W-1:0] readMux =
    selDivider ? DATA_W'(dividerCopy) :
    selReload ? DATA_W'(reloadCopy) :
    selFlags ? flagsWord : READ_ZERO;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regReadData <= READ_ZERO;
    end else if (regRead) begin
      regReadData <= readMux;
    end
  end

endmodule : independent_timeout_watchdog
`default_nettype wire

// ---- hw/osc_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
module osc_prescaler #(
  parameter int PRESCALE_W = watchdog_pkg::PRESCALE_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Oscillator edge and control
  input wire logic oscEdge,
  input wire logic run,
  input wire logic [watchdog_pkg::DIV_W-1:0] divSel,
  // Divided tick
  output logic tick
);
  import watchdog_pkg::*;

  logic [PRESCALE_W-1:0] count;
  logic [PRESCALE_W-1:0] limit;
  logic atLimit;

  // ----------------------------------------
  // Divisor decode
  // ----------------------------------------
  function automatic logic [PRESCALE_W-1:0] divLimit(input logic [DIV_W-1:0] code);
    logic [DIV_W-1:0] c;
    logic [PRESCALE_W:0] full;
    c = (code > DIVIDER_TOP_CODE) ? DIVIDER_TOP_CODE : code;
    full = (PRESCALE_W+1)'(1) << (32'(c) + DIVIDER_BASE_SHIFT);
    divLimit = PRESCALE_W'(full - (PRESCALE_W+1)'(1));
  endfunction : divLimit

  assign limit = divLimit(divSel);
  assign atLimit = (count >= limit);
  assign tick = run && oscEdge && atLimit;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (run && oscEdge) begin
      count <= atLimit ? '0 : count + PRESCALE_W'(1);
    end
  end

endmodule : osc_prescaler
`default_nettype wire

// ---- hw/update_tracker.sv ----
`timescale 1ns/10ps
`default_nettype none
module update_tracker #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Oscillator edge and default load
  input wire logic oscEdge,
  input wire logic loadDefault,
  // Bus side request
  input wire logic request,
  input wire logic [WIDTH-1:0] requestData,
  // Oscillator side copy
  output logic pending,
  output logic [WIDTH-1:0] oscCopy
);
  import watchdog_pkg::*;

  logic [WIDTH-1:0] held;
  logic [2:0] edges;
  logic done;

  assign done = pending && oscEdge && (edges == UPDATE_OSC_EDGES - 3'h1) && !request;

  // ----------------------------------------
  // Crossing into the oscillator side
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
      edges <= '0;
      held <= RESET_VALUE;
    end else if (request) begin
      pending <= 1'b1;
      edges <= '0;
      held <= requestData;
    end else if (done) begin
      pending <= 1'b0;
      edges <= '0;
    end else if (pending && oscEdge) begin
      edges <= edges + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oscCopy <= RESET_VALUE;
    end else if (loadDefault) begin
      oscCopy <= RESET_VALUE;
    end else if (done) begin
      oscCopy <= held;
    end
  end

endmodule : update_tracker
`default_nettype wire

// ---- hw/watchdog_pkg.sv ----
package watchdog_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DIVIDER = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'hc;

  localparam int DATA_W = 32;
  localparam int KEY_W = 16;
  localparam int COUNT_W = 12;
  localparam int DIV_W = 3;
  localparam int PRESCALE_W = 8;

  // ----------------------------------------
  // Command words
  // ----------------------------------------
  localparam logic [KEY_W-1:0] KEY_START = 16'hcccc;
  localparam logic [KEY_W-1:0] KEY_REFRESH = 16'haaaa;
  localparam logic [KEY_W-1:0] KEY_UNLOCK = 16'h5555;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_START = 12'hfff;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 12'h000;
  localparam logic [COUNT_W-1:0] RELOAD_RESET = 12'hfff;
  localparam logic [DIV_W-1:0] DIVIDER_RESET = 3'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
  localparam int FLAG_DIVIDER_BIT = 0;
  localparam int FLAG_RELOAD_BIT = 1;

  // ----------------------------------------
  // Prescaler: divide by 2^(code+2), code 7 as code 6
  // ----------------------------------------
  localparam logic [DIV_W-1:0] DIVIDER_TOP_CODE = 3'h6;
  localparam int DIVIDER_BASE_SHIFT = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int OSC_NOMINAL_HZ = 40_000;
  localparam int UPDATE_OSC_EDGES_MAX = 5;
  localparam logic [2:0] UPDATE_OSC_EDGES = 3'h2;

endpackage : watchdog_pkg
